//--- design/pcts_pipe_timing.sv
// pipeline issue timing and memory path contention controller
`timescale 1ns/10ps
module pcts_pipe_timing (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // decoder handshake
    input wire logic dec_valid,
    input wire pcts_pkg::pcts_class_t dec_class,
    input wire logic dec_taken,
    input wire logic dec_uses_load,
    output logic dec_ready,
    // core variant, level
    input wire logic dsp_variant,
    // contention sources
    input wire logic if_req,
    input wire logic ma_done,
    input wire logic mult_busy,
    input wire logic dsp_busy,
    // pipeline control
    output logic ma_req,
    output logic fetch_stall,
    output logic hold_later,
    output logic pipe_busy,
    output logic [pcts_pkg::CYC_W-1:0] cur_cycles,
    output logic [pcts_pkg::STG_W-1:0] cur_stages
);
    import pcts_pkg::*;

    pcts_state_t state;
    pcts_state_t next_state;
    logic accept;
    logic cls_ma;
    logic cls_mult_extend;
    logic cls_load_use;
    logic cls_dsp_use;
    logic load_use_hit;
    logic [CYC_W-1:0] base_cyc;
    logic [CYC_W-1:0] eff_cyc;
    logic [CYC_W:0] sum_cyc;
    logic [STG_W-1:0] stg_lookup;
    logic last_was_load;
    logic pend_ma;
    logic next_pend_ma;
    logic next_dec_ready;
    logic next_fetch_stall;
    logic cnt_load;
    logic [CYC_W-1:0] cnt_val;
    logic [CYC_W-1:0] remaining;
    logic cnt_last;

    // issue-cycle figure per class, before load and dsp penalties
    function automatic logic [CYC_W-1:0] cyc_lookup(input pcts_class_t c, input logic taken,
        input logic dsp, input logic mbusy);
        logic [CYC_W-1:0] r;
        r = CYC_ONE;
        case (c)
            PCTS_REG_OP: r = CYC_ONE; // [RULE1]
            PCTS_BRA: r = CYC_BRA; // [RULE2]
            PCTS_BCOND: r = taken ? CYC_BC_TAKEN : CYC_BC_NOT; // [RULE3]
            PCTS_BCOND_DLY: r = taken ? CYC_BCD_TAKEN : CYC_BC_NOT; // [RULE3]
            PCTS_LDC_SR: r = CYC_LDC_SR; // [RULE4]
            PCTS_LDCM_SR: r = CYC_LDCM_SR; // [RULE5]
            PCTS_STORE: r = CYC_ONE; // [RULE6]
            PCTS_LOAD: r = CYC_ONE; // [RULE7]
            PCTS_STC_BANK: r = CYC_STC_BANK; // [RULE8]
            PCTS_STC_OTHER: r = dsp ? CYC_STC_OTHER_DSP : CYC_STC_OTHER_BASE; // [RULE8] [RULE14]
            PCTS_MAC_XFER: r = mbusy ? CYC_ONE + CYC_PENALTY : CYC_ONE; // [RULE9]
            PCTS_MUL: r = mbusy ? CYC_MUL_MAX : CYC_MUL_MIN; // [RULE10]
            PCTS_DMAC: r = mbusy ? CYC_DMUL_MAX : CYC_DMUL_MIN; // [RULE11]
            PCTS_DMUL: r = mbusy ? CYC_DMUL_MAX : CYC_DMUL_MIN; // [RULE12]
            PCTS_MAC_TO_REG: r = mbusy ? CYC_ONE + CYC_PENALTY : CYC_ONE; // [RULE13]
            default: r = CYC_ONE;
        endcase
        return r;
    endfunction

    // stage depth per class
    function automatic logic [STG_W-1:0] stg_of(input pcts_class_t c);
        logic [STG_W-1:0] s;
        s = STG_3;
        case (c)
            PCTS_REG_OP, PCTS_BRA, PCTS_BCOND, PCTS_BCOND_DLY: s = STG_3; // [RULE1] [RULE3]
            PCTS_LDC_SR: s = STG_5; // [RULE4]
            PCTS_LDCM_SR: s = STG_7; // [RULE5]
            PCTS_STORE, PCTS_STC_OTHER, PCTS_MAC_XFER: s = STG_4; // [RULE6] [RULE8] [RULE9]
            PCTS_LOAD, PCTS_STC_BANK, PCTS_MAC_TO_REG: s = STG_5; // [RULE7] [RULE8] [RULE13]
            PCTS_MUL: s = STG_6; // [RULE10]
            PCTS_DMAC, PCTS_DMUL: s = STG_9; // [RULE11] [RULE12]
            default: s = STG_3;
        endcase
        return s;
    endfunction

    // class decode: which ones own a memory access stage
    assign accept = dec_valid && dec_ready;
    assign cls_ma = !(dec_class == PCTS_REG_OP || dec_class == PCTS_BRA ||
        dec_class == PCTS_BCOND || dec_class == PCTS_BCOND_DLY ||
        dec_class == PCTS_LDC_SR); // [RULE5] [RULE6] [RULE7] [RULE9]
    assign cls_mult_extend = mult_busy;
    assign cls_load_use = (dec_class == PCTS_LOAD || dec_class == PCTS_MAC_TO_REG ||
        dec_class == PCTS_LDCM_SR);
    assign cls_dsp_use = (dec_class == PCTS_MAC_TO_REG) && dsp_busy; // [RULE13]
    assign load_use_hit = last_was_load && dec_uses_load; // [RULE7]

    // total cycles including load-use and dsp penalties; a load-use hit on the
    // memory status load needs an eighth cycle that three bits cannot hold, so it saturates
    assign base_cyc = cyc_lookup(dec_class, dec_taken, dsp_variant, cls_mult_extend);
    assign sum_cyc = {1'b0, base_cyc} + (load_use_hit ? {1'b0, CYC_PENALTY} : '0)
        + (cls_dsp_use ? {1'b0, CYC_PENALTY} : '0); // [RULE7] [RULE13]
    assign eff_cyc = sum_cyc[CYC_W] ? '1 : sum_cyc[CYC_W-1:0];
    assign stg_lookup = stg_of(dec_class);

    // counter holds the issue cycles still owed after the accept cycle
    assign cnt_load = accept && (eff_cyc > CYC_ONE);
    assign cnt_val = eff_cyc - CYC_ONE;

    pcts_cycle_counter u_cnt (
        .core_clk(core_clk),
        .resetn(resetn),
        .load(cnt_load),
        .load_val(cnt_val),
        .remaining(remaining),
        .last(cnt_last)
    );

    // sequencing; the memory stage blocks further issue until it completes
    always_comb begin
        next_state = state;
        next_pend_ma = pend_ma;
        case (state)
            PCTS_IDLE: begin
                if (accept) begin
                    next_pend_ma = cls_ma;
                    if (eff_cyc > CYC_ONE) begin
                        next_state = PCTS_ISSUE; // [RULE2] [RULE4]
                    end else if (cls_ma) begin
                        next_state = PCTS_MA; // [RULE6]
                    end
                end
            end
            PCTS_ISSUE: begin
                if (cnt_last) begin
                    next_state = pend_ma ? PCTS_MA : PCTS_IDLE;
                end
            end
            PCTS_MA: begin
                if (ma_done) begin
                    next_state = PCTS_IDLE; // [RULE15]
                    next_pend_ma = 1'b0;
                end
            end
            default: begin
                next_state = PCTS_IDLE;
                next_pend_ma = 1'b0;
            end
        endcase
    end

    // registered outputs derive from the next state so they line up with it
    assign next_dec_ready = (next_state == PCTS_IDLE);
    assign next_fetch_stall = (next_state == PCTS_MA) && if_req; // [RULE15]

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= PCTS_IDLE;
            pend_ma <= 1'b0;
        end else begin
            state <= next_state;
            pend_ma <= next_pend_ma;
        end
    end

    // pipeline control flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dec_ready <= 1'b1;
            ma_req <= 1'b0;
            fetch_stall <= 1'b0;
            hold_later <= 1'b0;
            pipe_busy <= 1'b0;
        end else begin
            dec_ready <= next_dec_ready;
            ma_req <= (next_state == PCTS_MA); // [RULE5] [RULE6]
            fetch_stall <= next_fetch_stall; // [RULE15]
            hold_later <= next_fetch_stall; // [RULE15]
            pipe_busy <= (next_state != PCTS_IDLE);
        end
    end

    // figures of the instruction last accepted; a load leaves a load-use shadow
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_cycles <= '0;
            cur_stages <= '0;
            last_was_load <= 1'b0;
        end else if (accept) begin
            cur_cycles <= eff_cyc;
            cur_stages <= stg_lookup;
            last_was_load <= cls_load_use; // [RULE7]
        end
    end

    // checks on issue timing and memory path arbitration
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // one-cycle register ops and branch timing, read off the ready line
    chk_reg_op_single: assert property (accept && dec_class == PCTS_REG_OP // [RULE1]
        && !load_use_hit |=> dec_ready && cur_stages == STG_3)
        else $error("register op did not complete in one cycle");
    chk_bra_two_cycle: assert property (accept && dec_class == PCTS_BRA // [RULE2]
        && !load_use_hit |=> !dec_ready ##1 dec_ready)
        else $error("branch did not take two issue cycles");
    chk_bcond_taken: assert property (accept && dec_class == PCTS_BCOND // [RULE3]
        && dec_taken && !load_use_hit |=> !dec_ready [*2] ##1 dec_ready)
        else $error("taken conditional branch not three cycles");
    chk_bcond_not: assert property (accept && dec_class == PCTS_BCOND // [RULE3]
        && !dec_taken && !load_use_hit |=> dec_ready && cur_cycles == CYC_BC_NOT)
        else $error("conditional branch not taken is not one cycle");
    chk_bcond_dly: assert property (accept && dec_class == PCTS_BCOND_DLY // [RULE3]
        && !dec_taken && !load_use_hit |=> dec_ready && cur_cycles == CYC_BC_NOT)
        else $error("delayed branch not taken is not one cycle");
    chk_bcond_dly_taken: assert property (accept && dec_class == PCTS_BCOND_DLY // [RULE3]
        && dec_taken && !load_use_hit |=> !dec_ready ##1 dec_ready)
        else $error("taken delayed branch not two cycles");

    // status register loads; the memory form must not reach its access early
    chk_ldc_sr_five: assert property (accept && dec_class == PCTS_LDC_SR // [RULE4]
        && !load_use_hit |=> !dec_ready [*4] ##1 dec_ready)
        else $error("status register load not five cycles");
    chk_ldcm_sr_seven: assert property (accept && dec_class == PCTS_LDCM_SR // [RULE5]
        |=> (!dec_ready && !ma_req) [*6] ##1 ma_req)
        else $error("memory status load not seven cycles before access");
    chk_ldcm_sat: assert property (accept && dec_class == PCTS_LDCM_SR // [RULE5]
        && load_use_hit |=> cur_cycles == CYC_LDCM_SR)
        else $error("memory status load figure wrapped on a load-use hit");

    // memory-class issue figures and the load-use penalty
    chk_store_stages: assert property (accept && dec_class == PCTS_STORE // [RULE6]
        && !load_use_hit |=> ma_req && cur_stages == STG_4 && cur_cycles == CYC_ONE)
        else $error("store issue or stage depth wrong");
    chk_load_use_pen: assert property (accept && dec_class == PCTS_LOAD // [RULE7]
        && load_use_hit |=> cur_cycles == CYC_ONE + CYC_PENALTY && !dec_ready)
        else $error("load-use penalty not applied");
    chk_stc_bank_two: assert property (accept && dec_class == PCTS_STC_BANK // [RULE8]
        && !load_use_hit |=> !dec_ready ##1 ma_req)
        else $error("banked store not two cycles");
    chk_variant_pick: assert property (accept && dec_class == PCTS_STC_OTHER // [RULE14]
        && !load_use_hit
        |=> cur_cycles == $past(dsp_variant ? CYC_STC_OTHER_DSP : CYC_STC_OTHER_BASE))
        else $error("variant figure not selected");

    // multiplier and dsp figures follow the contention inputs seen at accept;
    // $past brings those inputs back one cycle later, when the figures show
    chk_mac_xfer: assert property (accept && dec_class == PCTS_MAC_XFER // [RULE9]
        && !load_use_hit |=> cur_stages == STG_4
        && cur_cycles == $past(mult_busy ? CYC_ONE + CYC_PENALTY : CYC_ONE))
        else $error("accumulator transfer timing wrong");
    chk_mul_bounds: assert property (accept && dec_class == PCTS_MUL // [RULE10]
        && !load_use_hit |=> cur_stages == STG_6
        && cur_cycles == $past(mult_busy ? CYC_MUL_MAX : CYC_MUL_MIN))
        else $error("single multiply outside cycle bounds");
    chk_dmac_bounds: assert property (accept && dec_class == PCTS_DMAC // [RULE11]
        && !load_use_hit |=> cur_stages == STG_9
        && cur_cycles == $past(mult_busy ? CYC_DMUL_MAX : CYC_DMUL_MIN))
        else $error("double multiply-accumulate timing wrong");
    chk_dmul_bounds: assert property (accept && dec_class == PCTS_DMUL // [RULE12]
        && !mult_busy && !load_use_hit |=> !dec_ready ##1 ma_req)
        else $error("double multiply not two cycles");
    chk_dmul_contend: assert property (accept && dec_class == PCTS_DMUL // [RULE12]
        && mult_busy && !load_use_hit |=> !dec_ready [*4] ##1 ma_req)
        else $error("contended double multiply not five cycles");
    chk_dsp_pen: assert property (accept && dec_class == PCTS_MAC_TO_REG // [RULE13]
        && dsp_busy && !mult_busy && !load_use_hit
        |=> cur_cycles == CYC_ONE + CYC_PENALTY && cur_stages == STG_5)
        else $error("dsp contention penalty missing");
    chk_mac_reg_stages: assert property (accept && dec_class == PCTS_MAC_TO_REG // [RULE13]
        && !dsp_busy && !mult_busy && !load_use_hit
        |=> cur_cycles == CYC_ONE && cur_stages == STG_5)
        else $error("accumulator to register timing wrong");

    // memory path: a colliding fetch is stalled and later stages wait for the access
    chk_fetch_stall: assert property (fetch_stall // [RULE15]
        |-> ma_req && hold_later && !dec_ready)
        else $error("fetch stalled outside memory stage");
    chk_stall_on_collide: assert property (ma_req && if_req && !ma_done // [RULE15]
        |=> fetch_stall && hold_later)
        else $error("colliding fetch not stalled");
    chk_ma_held: assert property (ma_req && !ma_done |=> ma_req && !dec_ready) // [RULE15]
        else $error("memory stage left before its access completed");
    chk_ma_release: assert property (ma_req && ma_done |=> !ma_req && dec_ready) // [RULE15]
        else $error("memory stage did not release");

    // scenarios the bench is expected to reach
    cov_store_collide: cover property (accept && dec_class == PCTS_STORE ##1 fetch_stall);
    cov_mul_contend: cover property (accept && dec_class == PCTS_DMUL && mult_busy);
    cov_load_use: cover property (accept && load_use_hit);
    cov_ldcm_full: cover property (accept && dec_class == PCTS_LDCM_SR ##[1:20] ma_done);
    cov_dsp_only: cover property (accept && dec_class == PCTS_MAC_TO_REG
        && dsp_busy && !mult_busy);

endmodule

//--- design/pcts_pkg.sv
// constants and types for the pipeline cycle timing and contention control
// Summary of operation
// RULE1: register, logical, shift and system arithmetic ops: one cycle, three stages.
// RULE2: unconditional branch occupies two issue cycles for the target redirect.
// RULE3: conditional branch 3/1 cycles, delayed conditional 2/1, taken/not taken.
// RULE4: status register load from general register: five cycles, five stages.
// RULE5: status register load from memory: seven cycles, seven stages, fetch contention.
// RULE6: stores issue in one cycle over four stages; memory stage contends with fetch.
// RULE7: loads issue in one cycle over five stages; load-use contention possible.
// RULE8: banked register store two cycles/five stages; others one or two, four stages.
// RULE9: transfers to/from multiply-accumulate registers: one cycle, four stages, contention.
// RULE10: single multiply at least one cycle, six stages, up to three under contention.
// RULE11: double multiply-accumulate at least two cycles, nine stages, up to five.
// RULE12: double multiply at least two cycles, nine stages, up to five.
// RULE13: accumulator/dsp to register: one cycle, five stages, several contention sources.
// RULE14: where two figures exist, base variant uses first, dsp variant second.
// RULE15: memory stage and fetch colliding stall fetch and hold later stages.
package pcts_pkg;

    // instruction classes delivered by the decoder
    typedef enum logic [3:0] {
        PCTS_REG_OP,
        PCTS_BRA,
        PCTS_BCOND,
        PCTS_BCOND_DLY,
        PCTS_LDC_SR,
        PCTS_LDCM_SR,
        PCTS_STORE,
        PCTS_LOAD,
        PCTS_STC_BANK,
        PCTS_STC_OTHER,
        PCTS_MAC_XFER,
        PCTS_MUL,
        PCTS_DMAC,
        PCTS_DMUL,
        PCTS_MAC_TO_REG
    } pcts_class_t;

    // controller states
    typedef enum logic [1:0] {
        PCTS_IDLE,
        PCTS_ISSUE,
        PCTS_MA
    } pcts_state_t;

    localparam int CYC_W = 3;
    localparam int STG_W = 4;

    // issue cycle figures
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_BRA = 3'h2;
    localparam logic [2:0] CYC_BC_TAKEN = 3'h3;
    localparam logic [2:0] CYC_BC_NOT = 3'h1;
    localparam logic [2:0] CYC_BCD_TAKEN = 3'h2;
    localparam logic [2:0] CYC_LDC_SR = 3'h5;
    localparam logic [2:0] CYC_LDCM_SR = 3'h7;
    localparam logic [2:0] CYC_STC_BANK = 3'h2;
    localparam logic [2:0] CYC_STC_OTHER_BASE = 3'h1;
    localparam logic [2:0] CYC_STC_OTHER_DSP = 3'h2;
    localparam logic [2:0] CYC_MUL_MIN = 3'h1;
    localparam logic [2:0] CYC_MUL_MAX = 3'h3;
    localparam logic [2:0] CYC_DMUL_MIN = 3'h2;
    localparam logic [2:0] CYC_DMUL_MAX = 3'h5;
    localparam logic [2:0] CYC_PENALTY = 3'h1;

    // pipeline stage figures
    localparam logic [3:0] STG_3 = 4'h3;
    localparam logic [3:0] STG_4 = 4'h4;
    localparam logic [3:0] STG_5 = 4'h5;
    localparam logic [3:0] STG_6 = 4'h6;
    localparam logic [3:0] STG_7 = 4'h7;
    localparam logic [3:0] STG_9 = 4'h9;

endpackage

//--- design/pcts_cycle_counter.sv
// down counter that times the remaining issue cycles of one instruction
`timescale 1ns/10ps
module pcts_cycle_counter (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // control
    input wire logic load,
    input wire logic [pcts_pkg::CYC_W-1:0] load_val,
    // state
    output logic [pcts_pkg::CYC_W-1:0] remaining,
    output logic last
);
    import pcts_pkg::*;

    logic [CYC_W-1:0] next_remaining;

    // load wins; otherwise count down and park at zero
    assign next_remaining = load ? load_val :
        (remaining != '0) ? remaining - CYC_ONE : remaining;
    assign last = (remaining == CYC_ONE);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            remaining <= '0;
        end else begin
            remaining <= next_remaining;
        end
    end

endmodule

//--- sim/pcts_pipe_timing_bench.sv
// self-checking bench for the pipeline issue timing controller
`timescale 1ns/10ps
module pcts_pipe_timing_bench;
    import pcts_pkg::*;

    // stimulus, all given a value at time zero
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic dec_valid = 1'b0;
    pcts_class_t dec_class = PCTS_REG_OP;
    logic dec_taken = 1'b0;
    logic dec_uses_load = 1'b0;
    logic dsp_variant = 1'b0;
    logic if_req = 1'b0;
    logic ma_done = 1'b0;
    logic mult_busy = 1'b0;
    logic dsp_busy = 1'b0;
    // observed outputs
    logic dec_ready;
    logic ma_req;
    logic fetch_stall;
    logic hold_later;
    logic pipe_busy;
    logic [CYC_W-1:0] cur_cycles;
    logic [STG_W-1:0] cur_stages;
    int num_errors = 0;
    int total_checks = 0;

    pcts_pipe_timing DUT (.core_clk(core_clk), .resetn(resetn), .dec_valid(dec_valid),
        .dec_class(dec_class), .dec_taken(dec_taken), .dec_uses_load(dec_uses_load),
        .dec_ready(dec_ready), .dsp_variant(dsp_variant), .if_req(if_req),
        .ma_done(ma_done), .mult_busy(mult_busy), .dsp_busy(dsp_busy), .ma_req(ma_req),
        .fetch_stall(fetch_stall), .hold_later(hold_later), .pipe_busy(pipe_busy),
        .cur_cycles(cur_cycles), .cur_stages(cur_stages));

    // 100 ns period
    always #50 core_clk = ~core_clk;

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // offer one instruction, then time its issue and memory phases
    task automatic run_op(input pcts_class_t cls, input logic tk, input logic dsp,
            input logic mb, input logic db, input logic ul,
            input int ecyc, input int estg, input int dly);
        int low;
        int seen_ma;
        logic mem;
        mem = !(cls inside {PCTS_REG_OP, PCTS_BRA, PCTS_BCOND, PCTS_BCOND_DLY, PCTS_LDC_SR});
        low = 0;
        seen_ma = 0;
        dec_valid <= 1'b1;
        dec_class <= cls;
        dec_taken <= tk;
        dsp_variant <= dsp;
        mult_busy <= mb;
        dsp_busy <= db;
        dec_uses_load <= ul;
        @(posedge core_clk);
        while (dec_ready !== 1'b1 && low < 40) begin
            @(posedge core_clk);
            low++;
        end
        dec_valid <= 1'b0;
        #1;
        check(8'(cur_cycles), 8'(ecyc));
        check(8'(cur_stages), 8'(estg));
        low = 0;
        @(posedge core_clk);
        // signals read at an edge are the values the design sampled there
        while (dec_ready !== 1'b1 && low < 40) begin
            low++;
            check(8'(pipe_busy), 8'h01);
            if (ma_req === 1'b1) begin
                seen_ma++;
                check(8'(fetch_stall), 8'(if_req));
                check(8'(hold_later), 8'(if_req));
                if (seen_ma > dly) begin
                    ma_done <= 1'b1;
                end
            end
            @(posedge core_clk);
        end
        ma_done <= 1'b0;
        check(8'(low), mem ? 8'(ecyc + 1 + dly) : 8'(ecyc - 1));
        check(8'(ma_req), 8'h00);
        check(8'(fetch_stall), 8'h00);
    endtask

    // back-to-back single-cycle ops, then a refused offer held over a branch
    task automatic sc_back_to_back();
        dec_valid <= 1'b1;
        dec_class <= PCTS_REG_OP;
        @(posedge core_clk);
        check(8'(dec_ready), 8'h01);
        @(posedge core_clk);
        check(8'(dec_ready), 8'h01);
        dec_class <= PCTS_BRA;
        @(posedge core_clk);
        check(8'(dec_ready), 8'h01);
        dec_class <= PCTS_REG_OP;
        #1;
        check(8'(cur_cycles), 8'h02);
        @(posedge core_clk);
        check(8'(dec_ready), 8'h00);
        @(posedge core_clk);
        check(8'(dec_ready), 8'h01);
        dec_valid <= 1'b0;
        #1;
        check(8'(cur_stages), 8'h03);
        @(posedge core_clk);
    endtask

    task automatic sc_branches();
        run_op(PCTS_BRA, '0, '0, '0, '0, '0, 2, 3, 0);
        run_op(PCTS_BCOND, '1, '0, '0, '0, '0, 3, 3, 0);
        run_op(PCTS_BCOND, '0, '0, '0, '0, '0, 1, 3, 0);
        run_op(PCTS_BCOND_DLY, '1, '0, '0, '0, '0, 2, 3, 0);
        run_op(PCTS_BCOND_DLY, '0, '0, '0, '0, '0, 1, 3, 0);
    endtask

    // fetch wanting the path while the memory stage runs, slow completion
    task automatic sc_memory();
        if_req <= 1'b1;
        run_op(PCTS_LDC_SR, '0, '0, '0, '0, '0, 5, 5, 0);
        run_op(PCTS_LDCM_SR, '0, '0, '0, '0, '0, 7, 7, 1);
        run_op(PCTS_STORE, '0, '0, '0, '0, '0, 1, 4, 3);
        if_req <= 1'b0;
        run_op(PCTS_LOAD, '0, '0, '0, '0, '0, 1, 5, 0);
        run_op(PCTS_LOAD, '0, '0, '0, '0, '1, 2, 5, 0);
        run_op(PCTS_LDCM_SR, '0, '0, '0, '0, '1, 7, 7, 0);
        run_op(PCTS_REG_OP, '0, '0, '0, '0, '1, 2, 3, 0);
    endtask

    task automatic sc_banked();
        run_op(PCTS_STC_BANK, '0, '0, '0, '0, '0, 2, 5, 0);
        run_op(PCTS_STC_OTHER, '0, '0, '0, '0, '0, 1, 4, 0);
        run_op(PCTS_STC_OTHER, '0, '1, '0, '0, '0, 2, 4, 0);
    endtask

    // multiplier and dsp contention flagged by the neighbours
    task automatic sc_multiplier();
        if_req <= 1'b1;
        run_op(PCTS_MAC_XFER, '0, '0, '0, '0, '0, 1, 4, 0);
        run_op(PCTS_MAC_XFER, '0, '0, '1, '0, '0, 2, 4, 0);
        run_op(PCTS_MUL, '0, '0, '0, '0, '0, 1, 6, 0);
        run_op(PCTS_MUL, '0, '0, '1, '0, '0, 3, 6, 0);
        run_op(PCTS_DMAC, '0, '0, '0, '0, '0, 2, 9, 0);
        run_op(PCTS_DMAC, '0, '0, '1, '0, '0, 5, 9, 0);
        run_op(PCTS_DMUL, '0, '0, '0, '0, '0, 2, 9, 0);
        run_op(PCTS_DMUL, '0, '0, '1, '0, '0, 5, 9, 0);
        run_op(PCTS_MAC_TO_REG, '0, '0, '0, '0, '0, 1, 5, 0);
        run_op(PCTS_MAC_TO_REG, '0, '0, '0, '1, '0, 2, 5, 0);
        run_op(PCTS_MAC_TO_REG, '0, '0, '1, '1, '0, 3, 5, 0);
        if_req <= 1'b0;
    endtask

    // main sequence: six reset cycles, then each scenario
    initial begin
        repeat (6) @(posedge core_clk);
        check(8'(dec_ready), 8'h01);
        check(8'(pipe_busy), 8'h00);
        check(8'(ma_req), 8'h00);
        resetn <= 1'b1;
        sc_back_to_back();
        sc_branches();
        sc_memory();
        sc_banked();
        sc_multiplier();
        summarize();
    end

    // watchdog well past the roughly 150 cycles the scenarios need
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        summarize();
    end

endmodule
